// >>> core/fspmt_core.v
// Purpose: Modem status (clear-to-send) and receive time-out logic.
// Assumes: Classic Wishbone slave; rx push and tick are single-cycle
//          pulses, rx empty a level, all from the same clock domain.
// Notes: One cycle registered ack; unmapped reads return zero.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "fspmt_regs.vh"

// Notes on behaviour
// - Modem status bit 4 reads as inverse of the active-low CTS pin.
// - Modem status bit 0 sets whenever CTS changes level, either way.
// - Modem status interrupt is flag AND interrupt-enable bit 3.
// - Writes to modem status change nothing.
// - Time-out interrupt only with time-out bit 7 and enable bit 0.
// - New RX word clears the idle counter; it counts baud ticks.
// - Counter equal to compare field with enables raises time-out.
// - Next RX word or RX FIFO empty clears the time-out interrupt.
// - Reserved bits of both registers read zero and do nothing.
module fspmt_core
#(
    parameter CNT_W = 7
)
(
    input wire clk_in,
    input wire sys_rst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire cts_n_in,
    input wire rx_push_in,
    input wire rx_empty_in,
    input wire baud_tick_in,
    output wire modem_irq_out,
    output wire timeout_irq_out,
    output wire [3:0] interrupt_enable_out
);

// ==========================================================
// State
reg [7:0] timeout_reg;
reg [3:0] interrupt_enable_reg;
reg cts_change_flag_reg;
reg cts_prev_reg;
reg timeout_irq_reg;
wire cts_n_sync;
wire idle_match;
wire [CNT_W-1:0] idle_count;
wire bus_req;
wire bus_wr;
wire bus_rd;
wire cts_changed;
wire [31:0] modem_line_status_reg;
wire timeout_irq_enable;
wire [CNT_W-1:0] timeout_compare_value;

function sel_hit;
    input [7:0] adr;
    input [7:0] off;
    begin
        sel_hit = (adr[7:2] == off[7:2]);
    end
endfunction

// ==========================================================
// Submodules
fspmt_sync2 #(.RESET_VAL(1'b1)) u_cts_sync
(
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(cts_n_in),
    .sync_out(cts_n_sync)
);

fspmt_idle_timer #(.CNT_W(CNT_W)) u_idle_timer
(
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .rx_push_in(rx_push_in),
    .baud_tick_in(baud_tick_in),
    .compare_in(timeout_compare_value),
    .match_out(idle_match),
    .count_out(idle_count)
);

// ==========================================================
// Bus decode; access completes on the ack edge only
assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
assign bus_wr = bus_req && wb_we_in;
assign bus_rd = bus_req && !wb_we_in;

assign timeout_irq_enable = timeout_reg[`FSPMT_TOCTL_EN_BIT];
assign timeout_compare_value = timeout_reg[CNT_W-1:0];

// Reserved bits tied to zero
assign modem_line_status_reg = {27'h000_0000, ~cts_n_sync, 3'h0,
    cts_change_flag_reg};

// ==========================================================
// Register writes; modem status has no write path
always @(posedge clk_in)
begin
    if (sys_rst_in)
    begin
        timeout_reg <= `FSPMT_TOCTL_RESET;
        interrupt_enable_reg <= `FSPMT_INTEN_RESET;
    end
    else if (bus_wr && wb_sel_in[0])
    begin
        if (sel_hit(wb_adr_in, `FSPMT_OFF_TIMEOUT))
            timeout_reg <= wb_dat_in[7:0];
        else if (sel_hit(wb_adr_in, `FSPMT_OFF_INT_ENABLE))
            interrupt_enable_reg <= wb_dat_in[3:0];
        // Modem status offset falls through untouched
    end
end

// ==========================================================
// Read mux and ack
always @(posedge clk_in)
begin
    if (sys_rst_in)
    begin
        wb_ack_out <= 1'b0;
        wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
        wb_ack_out <= bus_req;
        wb_dat_out <= 32'h0000_0000;
        if (bus_rd)
        begin
            if (sel_hit(wb_adr_in, `FSPMT_OFF_MODEM_STATUS))
                wb_dat_out <= modem_line_status_reg;
            else if (sel_hit(wb_adr_in, `FSPMT_OFF_TIMEOUT))
                wb_dat_out <= {24'h00_0000, timeout_reg};
            else if (sel_hit(wb_adr_in, `FSPMT_OFF_INT_ENABLE))
                wb_dat_out <= {28'h000_0000, interrupt_enable_reg};
            else if (sel_hit(wb_adr_in, `FSPMT_OFF_IRQ_STATUS))
                wb_dat_out <= {22'h00_0000, 1'b0, idle_count,
                    timeout_irq_reg, modem_irq_out};
        end
    end
end

// ==========================================================
// CTS change flag; a change in the read cycle wins over clear
assign cts_changed = (cts_n_sync != cts_prev_reg);

always @(posedge clk_in)
begin
    if (sys_rst_in)
    begin
        cts_prev_reg <= 1'b1;
        cts_change_flag_reg <= 1'b0;
    end
    else
    begin
        cts_prev_reg <= cts_n_sync;
        if (cts_changed)
            cts_change_flag_reg <= 1'b1;
        else if (bus_rd && sel_hit(wb_adr_in, `FSPMT_OFF_MODEM_STATUS))
            cts_change_flag_reg <= 1'b0;
    end
end

assign modem_irq_out = cts_change_flag_reg &&
    interrupt_enable_reg[`FSPMT_INTEN_MS_BIT];

// ==========================================================
// Time-out interrupt; clear by new word or empty FIFO
always @(posedge clk_in)
begin
    if (sys_rst_in)
        timeout_irq_reg <= 1'b0;
    else if (rx_push_in || rx_empty_in)
        timeout_irq_reg <= 1'b0;
    else if (idle_match && timeout_irq_enable &&
        interrupt_enable_reg[`FSPMT_INTEN_RXTO_BIT])
        timeout_irq_reg <= 1'b1;
end

// Enables gate the output too, so a disable drops it at once
assign timeout_irq_out = timeout_irq_reg && timeout_irq_enable &&
    interrupt_enable_reg[`FSPMT_INTEN_RXTO_BIT];
assign interrupt_enable_out = interrupt_enable_reg;

endmodule

// >>> core/fspmt_regs.vh
// Purpose: Offsets, field positions and reset values of the block.
// Assumes: Byte-addressed classic Wishbone slave, 32-bit data.
// Notes: Offsets are byte addresses within the block.
`ifndef FSPMT_REGS_VH
`define FSPMT_REGS_VH

// ==========================================================
// Register offsets
`define FSPMT_OFF_MODEM_STATUS 8'h18
`define FSPMT_OFF_TIMEOUT 8'h1c
`define FSPMT_OFF_INT_ENABLE 8'h20
`define FSPMT_OFF_IRQ_STATUS 8'h24

// ==========================================================
// Field positions
`define FSPMT_MLS_CTS_BIT 4
`define FSPMT_MLS_CHG_BIT 0
`define FSPMT_TOCTL_EN_BIT 7
`define FSPMT_TOCTL_CMP_MSB 6
`define FSPMT_INTEN_RXTO_BIT 0
`define FSPMT_INTEN_MS_BIT 3

// ==========================================================
// Reset values
`define FSPMT_TOCTL_RESET 8'h00
`define FSPMT_INTEN_RESET 4'h0

`endif

// >>> core/fspmt_sync2.v
// Purpose: Two-flop synchroniser for an asynchronous level.
// Assumes: Input comes from a pin outside the clock domain.
// Notes: First flop is read only by the second flop.
`timescale 1ns/1ps

module fspmt_sync2
#(
    parameter RESET_VAL = 1'b1
)
(
    input wire clk_in,
    input wire sys_rst_in,
    input wire async_in,
    output wire sync_out
);

// ==========================================================
// Synchroniser chain
reg meta_reg;
reg sync_reg;

// Resets to the idle level so no false change at start
always @(posedge clk_in)
begin
    if (sys_rst_in)
    begin
        meta_reg <= RESET_VAL;
        sync_reg <= RESET_VAL;
    end
    else
    begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule

// >>> core/fspmt_idle_timer.v
// Purpose: Receive idle tick counter with compare and hold.
// Assumes: Tick and push come from the same clock domain.
// Notes: Counter saturates at the compare value.
`timescale 1ns/1ps

module fspmt_idle_timer
#(
    parameter CNT_W = 7
)
(
    input wire clk_in,
    input wire sys_rst_in,
    input wire rx_push_in,
    input wire baud_tick_in,
    input wire [CNT_W-1:0] compare_in,
    output wire match_out,
    output wire [CNT_W-1:0] count_out
);

// ==========================================================
// Idle tick counter
reg [CNT_W-1:0] idle_tick_counter_reg;
reg [CNT_W-1:0] idle_tick_counter_next;

assign match_out = (idle_tick_counter_reg == compare_in);
assign count_out = idle_tick_counter_reg;

// Restart on each new word, else count ticks until match
always @*
begin
    idle_tick_counter_next = idle_tick_counter_reg;
    if (rx_push_in)
        idle_tick_counter_next = {CNT_W{1'b0}};
    else if (baud_tick_in && !match_out)
        idle_tick_counter_next = idle_tick_counter_reg
            + {{(CNT_W-1){1'b0}}, 1'b1};
end

always @(posedge clk_in)
begin
    if (sys_rst_in)
        idle_tick_counter_reg <= {CNT_W{1'b0}};
    else
        idle_tick_counter_reg <= idle_tick_counter_next;
end

endmodule

// >>> verif/fspmt_cts_model.sv
// Purpose: Remote device driving the clear-to-send pin.
// Assumes: flip is called just after a rising clock edge.
// Notes: Pin rests high, its inactive level.
`timescale 1ns/1ps
module fspmt_cts_model(
    output logic cts_n_out
);
    // =====
    // Idle at reset; each flip is one level change
    initial cts_n_out = 1'b1;
    task automatic flip();
        cts_n_out <= ~cts_n_out;
    endtask
endmodule

// >>> verif/fspmt_core_chk.sv
// Purpose: Port checks for status and time-out logic.
// Assumes: One clock, sync reset.
// Notes: CTS bit and read-clear checks wait until the pin has been quiet; the change check does not.
`timescale 1ns/1ps
`include "fspmt_regs.vh"
module fspmt_core_chk(
    input logic clk_in,
    input logic sys_rst_in,
    input logic wb_we_in,
    input logic [7:0] wb_adr_in,
    input logic [31:0] wb_dat_out,
    input logic wb_ack_out,
    input logic cts_n_in,
    input logic rx_push_in,
    input logic rx_empty_in,
    input logic modem_irq_out,
    input logic timeout_irq_out,
    input logic [3:0] interrupt_enable_out
);
    logic [2:0] calm_reg;
    logic last_reg;
    wire rd_ms = wb_ack_out && !wb_we_in
        && wb_adr_in == `FSPMT_OFF_MODEM_STATUS;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // =====
    // Quiet count; sync delay means a fresh edge is not yet visible
    always_ff @(posedge clk_in)
    begin
        last_reg <= cts_n_in;
        if (sys_rst_in || cts_n_in != last_reg)
            calm_reg <= 3'h0;
        else if (calm_reg != 3'h7)
            calm_reg <= calm_reg + 3'h1;
    end
    ms_gate_a: assert property (modem_irq_out |->
        interrupt_enable_out[3]) else $error("modem irq ungated");
    to_gate_a: assert property (timeout_irq_out |->
        interrupt_enable_out[0]) else $error("timeout irq ungated");
    push_clr_a: assert property (rx_push_in |=>
        !timeout_irq_out) else $error("push kept timeout");
    empty_clr_a: assert property (rx_empty_in |=>
        !timeout_irq_out) else $error("empty kept timeout");
    cts_bit_a: assert property (rd_ms && calm_reg == 3'h7 |->
        wb_dat_out[4] == !cts_n_in) else $error("cts bit wrong");
    ms_rsvd_a: assert property (rd_ms |-> wb_dat_out[31:5] == 0
        && wb_dat_out[3:1] == 0) else $error("reserved bits set");
    cts_flag_a: assert property ($changed(cts_n_in)
        && interrupt_enable_out[3] |-> ##[1:6] modem_irq_out)
        else $error("cts change missed");
    rd_clear_a: assert property (rd_ms && calm_reg == 3'h7
        |=> !modem_irq_out) else $error("read left flag");
    cover property (rd_ms);
    cover property ($rose(timeout_irq_out));
    cover property ($rose(modem_irq_out));
endmodule
bind fspmt_core fspmt_core_chk u_chk(.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .cts_n_in(cts_n_in),
    .rx_push_in(rx_push_in), .rx_empty_in(rx_empty_in),
    .modem_irq_out(modem_irq_out), .timeout_irq_out(timeout_irq_out),
    .interrupt_enable_out(interrupt_enable_out));

// >>> verif/fspmt_core_tb.sv
// Purpose: Self-checking bench for status and time-out logic.
// Assumes: One-wait Wishbone slave.
// Notes: Irq levels are sampled on the falling edge.
`timescale 1ns/1ps
`include "fspmt_regs.vh"
module fspmt_core_tb;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, cyc = 1'b0, we = 1'b0;
    logic ack, mirq, tirq, cts_n, push = 1'b0, empty = 1'b1, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] ie;
    int n_errors = 0, n_compared = 0;
    fspmt_cts_model u_cts(.cts_n_out(cts_n));
    fspmt_core u_dut(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .cts_n_in(cts_n), .rx_push_in(push),
        .rx_empty_in(empty), .baud_tick_in(tick), .modem_irq_out(mirq),
        .timeout_irq_out(tirq), .interrupt_enable_out(ie));
    // =====
    initial forever #4 clk_in = ~clk_in;
    task automatic check(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // One classic cycle; answer taken at the ack edge only
    task automatic bus(input logic w, input logic [7:0] a, d);
        int n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
            @(posedge clk_in);
        while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        cyc <= 1'b0;
        check("ack", 32'h1, ack);
    endtask
    task automatic ticks(input int k, input logic p);
        repeat (k)
        begin
            @(posedge clk_in);
            tick <= !p;
            push <= p;
            @(posedge clk_in);
            tick <= 1'b0;
            push <= 1'b0;
        end
    endtask
    // Selects the pin after the wait; a value argument would be stale
    task automatic look(input int k, input logic [31:0] e, input logic w);
        repeat (k) @(posedge clk_in);
        @(negedge clk_in);
        check("irq", e, {31'h0, w ? tirq : mirq});
    endtask
    // =====
    task automatic t_regs();
        bus(1'b0, `FSPMT_OFF_TIMEOUT, 8'h00);
        check("timeout reset", 32'h0, q);
        bus(1'b1, `FSPMT_OFF_TIMEOUT, 8'hff);
        bus(1'b0, `FSPMT_OFF_TIMEOUT, 8'h00);
        check("timeout", 32'hff, q);
        bus(1'b0, 8'h40, 8'h00);
        check("unmapped", 32'h0, q);
        $display("test regs done");
    endtask
    task automatic t_cts();
        bus(1'b1, `FSPMT_OFF_INT_ENABLE, 8'h08);
        u_cts.flip();
        look(8, 32'h1, 1'b0);
        bus(1'b0, `FSPMT_OFF_MODEM_STATUS, 8'h00);
        check("status", 32'h11, q);
        bus(1'b1, `FSPMT_OFF_MODEM_STATUS, 8'hff);
        bus(1'b0, `FSPMT_OFF_MODEM_STATUS, 8'h00);
        check("status read", 32'h10, q);
        u_cts.flip();
        look(8, 32'h1, 1'b0);
        bus(1'b0, `FSPMT_OFF_MODEM_STATUS, 8'h00);
        check("status rise", 32'h01, q);
        $display("test cts done");
    endtask
    task automatic t_to();
        bus(1'b1, `FSPMT_OFF_TIMEOUT, 8'h83);
        bus(1'b1, `FSPMT_OFF_INT_ENABLE, 8'h01);
        check("inten", 32'h1, {28'h0, ie});
        empty <= 1'b0;
        ticks(1, 1'b1);
        ticks(2, 1'b0);
        look(1, 32'h0, 1'b1);
        ticks(1, 1'b0);
        look(1, 32'h1, 1'b1);
        ticks(5, 1'b0);
        bus(1'b0, `FSPMT_OFF_IRQ_STATUS, 8'h00);
        check("held", 32'h3, q[8:2]);
        ticks(1, 1'b1);
        look(0, 32'h0, 1'b1);
        ticks(3, 1'b0);
        look(1, 32'h1, 1'b1);
        @(posedge clk_in);
        empty <= 1'b1;
        look(1, 32'h0, 1'b1);
        bus(1'b1, `FSPMT_OFF_TIMEOUT, 8'h03);
        empty <= 1'b0;
        ticks(1, 1'b1);
        ticks(4, 1'b0);
        look(1, 32'h0, 1'b1);
        $display("test timeout done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence, then a watchdog well past its length
    initial
    begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_cts();
        t_to();
        conclude();
    end
    initial
    begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        conclude();
    end
endmodule
